/* File: system_clock_post_dividers.sv */
// three system clock post-dividers behind a 16-bit register port
// assumes osc_pulse and pll_pulse are one-cycle pulses synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module system_clock_post_dividers
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // clock path
  input  wire logic        bypass_mode,
  input  wire logic        osc_pulse,
  input  wire logic        pll_pulse,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // divided clocks
  output logic             first_system_clock,
  output logic             second_system_clock,
  output logic             third_system_clock,
  // enable state
  output logic             first_divider_on,
  output logic             second_divider_on,
  output logic             third_divider_on
);

  localparam int unsigned N = sysclk_div_pkg::NUM_DIV;

  ////////////////////////////////////////////////////////////////////////////////
  // clock path select

  logic src_pulse;

  // one source feeds all three, so a ratio holds whether or not the pll is in use
  assign src_pulse = bypass_mode ? osc_pulse : pll_pulse;  // [RL1]

  ////////////////////////////////////////////////////////////////////////////////
  // registers and dividers

  logic [N-1:0]       hit;
  logic [N-1:0]       wr_hit;
  logic [N-1:0]       on;
  logic [N-1:0]       tick;
  logic [N-1:0][4:0]  ratio;
  logic [N-1:0][15:0] rd_val;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_div
      assign hit[gi] = (reg_addr == sysclk_div_pkg::div_offset(gi));
      // address-qualified write strobe, shared by the word and its checks
      assign wr_hit[gi] = reg_wr && hit[gi];

      divider_ctrl_reg u_ctrl
      (
        .mclk     (mclk),
        .rst      (rst),
        .wr       (wr_hit[gi]),
        .wdata    (reg_wdata),
        .on_q     (on[gi]),
        .ratio_q  (ratio[gi]),
        .rd_value (rd_val[gi])
      );

      post_divider u_div
      (
        .mclk      (mclk),
        .rst       (rst),
        .src_pulse (src_pulse),
        .on        (on[gi]),
        .ratio     (ratio[gi]),
        .tick_q    (tick[gi])
      );
    end
  endgenerate

  assign first_system_clock  = tick[0];
  assign second_system_clock = tick[1];
  assign third_system_clock  = tick[2];
  assign first_divider_on    = on[0];
  assign second_divider_on   = on[1];
  assign third_divider_on    = on[2];

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  logic [15:0] rd_mux;
  logic [15:0] rdata_q;

  // unmapped addresses read as zero
  always_comb
  begin
    rd_mux = 16'h0000;
    for (int i = 0; i < N; i++)
      if (hit[i])
        rd_mux = rd_val[i];
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_q <= 16'h0000;
    else if (reg_rd)
      rdata_q <= rd_mux;  // [RL6]
    else
      rdata_q <= 16'h0000;
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checking helpers: pulses since the last tick, and a settled flag set at the
  // first tick after the control word was last written or switched on
  // seen_q saturates at 7 so a stalled divider cannot wrap back into range

  logic [N-1:0][2:0] seen_q;
  logic [N-1:0]      settled_q;

  generate
    for (gi = 0; gi < N; gi++)
    begin : g_chk
      always_ff @(posedge mclk)
      begin
        if (rst || tick[gi])
          seen_q[gi] <= {2'b00, src_pulse};
        else if (src_pulse && seen_q[gi] != 3'h7)
          seen_q[gi] <= seen_q[gi] + 3'h1;
      end

      always_ff @(posedge mclk)
      begin
        if (rst || !on[gi] || wr_hit[gi])
          settled_q[gi] <= 1'b0;
        else if (tick[gi])
          settled_q[gi] <= 1'b1;
      end

      // period in source pulses matches the ratio once settled
      ratio_period_a : assert property (  // [RL2] [RL3] [RL4]
        @(posedge mclk) disable iff (rst)
        (tick[gi] && settled_q[gi] && !$past(wr_hit[gi]))
        |-> ({1'b0, seen_q[gi]} ==
             {1'b0, sysclk_div_pkg::term_of(ratio[gi])} + 4'h1)
      ) else $error("divided clock period does not match ratio");

      // disabled divider stays quiet
      disabled_quiet_a : assert property (  // [RL5]
        @(posedge mclk) disable iff (rst)
        !on[gi] |=> !tick[gi]
      ) else $error("tick from a disabled divider");

      // every tick follows a pulse of the selected path
      path_source_a : assert property (  // [RL1]
        @(posedge mclk) disable iff (rst)
        tick[gi]
        |-> ($past(bypass_mode) ? $past(osc_pulse) : $past(pll_pulse))
      ) else $error("tick without a pulse on the selected path");

      // divide by 1 ticks on every source pulse
      div_one_a : assert property (  // [RL2] [RL3] [RL4]
        @(posedge mclk) disable iff (rst)
        (on[gi] && ratio[gi] == sysclk_div_pkg::RATIO_DIV1 && src_pulse
         && !(reg_wr && hit[gi]))
        |=> tick[gi]
      ) else $error("divide by 1 missed a source pulse");

      // reset leaves the divider enabled at divide by 4
      reset_defaults_a : assert property (  // [RL5] [RL2] [RL3] [RL4]
        @(posedge mclk)
        rst |=> (rd_val[gi] == sysclk_div_pkg::CTRL_RESET)
      ) else $error("control word wrong after reset");

      // a divided period of two or four never ticks twice in a row
      tick_gap_a : assert property (  // [RL2] [RL3] [RL4]
        @(posedge mclk) disable iff (rst)
        (tick[gi] && ratio[gi] != sysclk_div_pkg::RATIO_DIV1) |=> !tick[gi]
      ) else $error("back to back ticks above divide by 1");

      // a write to this word lands at its strobe edge
      write_lands_a : assert property (  // [RL2] [RL3] [RL4] [RL5]
        @(posedge mclk) disable iff (rst)
        wr_hit[gi]
        |=> (on[gi] == $past(reg_wdata[sysclk_div_pkg::ON_BIT]))
            && (ratio[gi] == $past(reg_wdata[4:0]))
      ) else $error("write did not land in the control word");

      // without a write to it, a control word keeps its value
      word_holds_a : assert property (  // [RL5]
        @(posedge mclk) disable iff (rst)
        !wr_hit[gi] |=> ($stable(on[gi]) && $stable(ratio[gi]))
      ) else $error("control word changed without a write");

      // a read of this word returns its enable and ratio
      read_fields_a : assert property (  // [RL2] [RL3] [RL4] [RL5]
        @(posedge mclk) disable iff (rst)
        (reg_rd && hit[gi])
        |=> (reg_rdata[15] == $past(on[gi])) && (reg_rdata[4:0] == $past(ratio[gi]))
      ) else $error("read data does not match the control word");

      // the first tick follows the reset, never comes with it
      reset_quiet_a : assert property (  // [RL5]
        @(posedge mclk)
        rst |=> (!tick[gi] && on[gi])
      ) else $error("tick or disabled divider right after reset");

      // a write to an unmapped address leaves this word alone
      unmapped_write_a : assert property (
        @(posedge mclk) disable iff (rst)
        (reg_wr && !(|hit)) |=> $stable(rd_val[gi])
      ) else $error("unmapped write changed a control word");

      // counting restarts from zero when the divider is switched back on
      restart_count_a : assert property (  // [RL5]
        @(posedge mclk) disable iff (rst)
        ($rose(on[gi]) && ratio[gi] != sysclk_div_pkg::RATIO_DIV1) |=> !tick[gi]
      ) else $error("tick too early after enable");

      // once settled, no more source pulses than the ratio pass without a tick
      period_bound_a : assert property (  // [RL2] [RL3] [RL4]
        @(posedge mclk) disable iff (rst)
        settled_q[gi]
        |-> ({1'b0, seen_q[gi]} <= {1'b0, sysclk_div_pkg::term_of(ratio[gi])} + 4'h1)
      ) else $error("divider missed its tick");

      // an idle selected path gives no tick, whatever the other path does
      idle_path_a : assert property (  // [RL1]
        @(posedge mclk) disable iff (rst)
        (bypass_mode ? !osc_pulse : !pll_pulse)
        |=> !tick[gi]
      ) else $error("tick while the selected path was idle");

      // a tick only comes from a divider that was on
      tick_needs_on_a : assert property (  // [RL5]
        @(posedge mclk) disable iff (rst)
        tick[gi] |-> $past(on[gi])
      ) else $error("tick from a divider that was off");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // register port checks

  // reserved middle bits read as zero
  reserved_zero_a : assert property (  // [RL6]
    @(posedge mclk) disable iff (rst)
    reg_rd |=> (reg_rdata[14:5] == 10'h000)
  ) else $error("reserved bits read nonzero");

  // a write is read back with only kept bits
  write_readback_a : assert property (  // [RL5] [RL6]
    @(posedge mclk) disable iff (rst)
    (reg_wr && |hit ##1 reg_rd && $stable(reg_addr))
    |=> (reg_rdata == ($past(reg_wdata, 2) & sysclk_div_pkg::KEEP_MASK))
  ) else $error("read back differs from written value");

  // unmapped read gives zero
  unmapped_zero_a : assert property (
    @(posedge mclk) disable iff (rst)
    (reg_rd && !(|hit)) |=> (reg_rdata == 16'h0000)
  ) else $error("unmapped read is nonzero");

  // read data only in the cycle after the strobe
  read_window_a : assert property (
    @(posedge mclk) disable iff (rst)
    !reg_rd |=> (reg_rdata == 16'h0000)
  ) else $error("read data outside its cycle");

  // the port reads zero straight after reset
  reset_rdata_a : assert property (
    @(posedge mclk)
    rst |=> (reg_rdata == 16'h0000)
  ) else $error("read data nonzero after reset");

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios

  cov_div4_period_c : cover property (
    @(posedge mclk) disable iff (rst)
    tick[0] && settled_q[0] && ratio[0] == sysclk_div_pkg::RATIO_DIV4
  );

  cov_div2_bypass_c : cover property (
    @(posedge mclk) disable iff (rst)
    bypass_mode && tick[1] && settled_q[1] && ratio[1] == sysclk_div_pkg::RATIO_DIV2
  );

  cov_disable_c : cover property (
    @(posedge mclk) disable iff (rst)
    on[2] ##1 !on[2]
  );

  cov_readback_c : cover property (
    @(posedge mclk) disable iff (rst)
    reg_wr && hit[0] ##1 reg_rd && hit[0]
  );

  cov_div1_c : cover property (
    @(posedge mclk) disable iff (rst)
    tick[2] && settled_q[2] && ratio[2] == sysclk_div_pkg::RATIO_DIV1
  );

endmodule : system_clock_post_dividers
`default_nettype wire

/* File: sysclk_div_pkg.sv */
// constants, field layout and ratio decoding shared by the post-divider files
// assumes a 16-bit register port addressed by the printed byte offsets
//
// What this block does
// RL1 - each divider takes the bypass path and the pll path, ratio applies in both
// RL2 - first divider ratio: 00000 div1, 00001 div2, 00011 div4, reset 00011
// RL3 - second divider ratio: same codes and reset; 00010 and 00100-11111 reserved
// RL4 - third divider ratio: same codes and reset; remaining codes reserved
// RL5 - bit 15 is a read/write enable, reset 1; 0 disables, 1 enables
// RL6 - bits 14 to 5 read zero and writes to them are dropped
// RL7 - software writes only defined ratio codes; reserved codes behave arbitrarily
package sysclk_div_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned NUM_DIV = 3;

  // register offsets
  localparam logic [15:0] FIRST_SYSTEM_CLOCK_DIVIDER_CTRL_OFS = 16'h1C8C;
  localparam logic [15:0] SECOND_SYSTEM_CLOCK_DIVIDER_CTRL_OFS = 16'h1C8E;
  localparam logic [15:0] THIRD_SYSTEM_CLOCK_DIVIDER_CTRL_OFS = 16'h1C90;

  ////////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int unsigned ON_BIT   = 15;
  localparam int unsigned RATIO_HI = 4;
  localparam int unsigned RATIO_LO = 0;
  localparam int unsigned RATIO_W  = 5;
  localparam logic [15:0] KEEP_MASK = 16'h801F;

  // values after reset
  localparam logic               ON_RESET    = 1'b1;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 5'h03;
  localparam logic [15:0]        CTRL_RESET  = 16'h8003;

  // defined ratio codes
  localparam logic [RATIO_W-1:0] RATIO_DIV1 = 5'h00;
  localparam logic [RATIO_W-1:0] RATIO_DIV2 = 5'h01;
  localparam logic [RATIO_W-1:0] RATIO_DIV4 = 5'h03;

  // divider counter width and terminal counts
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] TERM_DIV1 = 3'h0;
  localparam logic [CNT_W-1:0] TERM_DIV2 = 3'h1;
  localparam logic [CNT_W-1:0] TERM_DIV4 = 3'h3;

  // clock rate
  localparam int unsigned MCLK_HZ = 40000000;

  ////////////////////////////////////////////////////////////////////////////////
  // reserved codes fall back to divide by 4, the reset ratio
  function automatic logic [CNT_W-1:0] term_of(input logic [RATIO_W-1:0] ratio);
    case (ratio)
      RATIO_DIV1: term_of = TERM_DIV1;
      RATIO_DIV2: term_of = TERM_DIV2;
      RATIO_DIV4: term_of = TERM_DIV4;
      default:    term_of = TERM_DIV4;
    endcase
  endfunction : term_of

  function automatic logic [15:0] div_offset(input int unsigned idx);
    case (idx)
      0:       div_offset = FIRST_SYSTEM_CLOCK_DIVIDER_CTRL_OFS;
      1:       div_offset = SECOND_SYSTEM_CLOCK_DIVIDER_CTRL_OFS;
      default: div_offset = THIRD_SYSTEM_CLOCK_DIVIDER_CTRL_OFS;
    endcase
  endfunction : div_offset

endpackage : sysclk_div_pkg

/* File: divider_ctrl_reg.sv */
// one divider control word: enable bit and ratio field
// assumes the parent decodes the address and gives a one-cycle write strobe
`timescale 1ns/10ps
`default_nettype none
module divider_ctrl_reg
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // write side
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  // fields
  output logic             on_q,
  output logic [4:0]       ratio_q,
  output logic [15:0]      rd_value
);

  always_ff @(posedge mclk)
  begin
    if (rst)
      on_q <= sysclk_div_pkg::ON_RESET;
    else if (wr)
      on_q <= wdata[sysclk_div_pkg::ON_BIT];  // [RL5]
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      ratio_q <= sysclk_div_pkg::RATIO_RESET;  // [RL2] [RL3] [RL4]
    else if (wr)
      ratio_q <= wdata[sysclk_div_pkg::RATIO_HI:sysclk_div_pkg::RATIO_LO];
  end

  // middle bits are never stored, so they read as zero
  assign rd_value = {on_q, 10'h000, ratio_q};  // [RL6]

endmodule : divider_ctrl_reg
`default_nettype wire

/* File: post_divider.sv */
// one post-divider: counts source pulses and emits one tick per ratio
// assumes src_pulse is already the selected bypass or pll clock pulse
`timescale 1ns/10ps
`default_nettype none
module post_divider #(
  parameter int unsigned CNT_W = sysclk_div_pkg::CNT_W
)
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // source and control
  input  wire logic       src_pulse,
  input  wire logic       on,
  input  wire logic [4:0] ratio,
  // divided clock tick
  output logic            tick_q
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] term;

  assign term = sysclk_div_pkg::term_of(ratio);

  // >= keeps the count bounded when the ratio shrinks mid-period
  always_ff @(posedge mclk)
  begin
    if (rst || !on)
      cnt_q <= '0;  // [RL5]
    else if (src_pulse)
    begin
      if (cnt_q >= term)
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + 1'b1;  // [RL2] [RL3] [RL4]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || !on)
      tick_q <= 1'b0;  // [RL5]
    else
      tick_q <= src_pulse && (cnt_q >= term);
  end

endmodule : post_divider
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the three system clock post-dividers
// assumes the design's own assertions sit in its files; drives all ports directly
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  ////////////////////////////////////////////////////////////////////////////////
  logic        mclk;
  logic        rst;
  logic        bypass_mode;
  logic        osc_pulse;
  logic        pll_pulse;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        first_system_clock;
  logic        second_system_clock;
  logic        third_system_clock;
  logic        first_divider_on;
  logic        second_divider_on;
  logic        third_divider_on;
  logic        run_osc;
  logic        run_pll;
  int          errors;
  int          n_compared;

  typedef struct {logic [4:0] code; logic byp; int n;} row_s;
  row_s rows [6] = '{'{5'h00, 1'b0, 1}, '{5'h01, 1'b0, 2}, '{5'h03, 1'b0, 4},
                     '{5'h00, 1'b1, 1}, '{5'h01, 1'b1, 2}, '{5'h03, 1'b1, 4}};
  logic [15:0] ofs [3] = '{sysclk_div_pkg::FIRST_SYSTEM_CLOCK_DIVIDER_CTRL_OFS,
                           sysclk_div_pkg::SECOND_SYSTEM_CLOCK_DIVIDER_CTRL_OFS,
                           sysclk_div_pkg::THIRD_SYSTEM_CLOCK_DIVIDER_CTRL_OFS};

  system_clock_post_dividers i_system_clock_post_dividers (
    .mclk(mclk), .rst(rst), .bypass_mode(bypass_mode), .osc_pulse(osc_pulse),
    .pll_pulse(pll_pulse), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_system_clock(first_system_clock),
    .second_system_clock(second_system_clock), .third_system_clock(third_system_clock),
    .first_divider_on(first_divider_on), .second_divider_on(second_divider_on),
    .third_divider_on(third_divider_on)
  );

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // source pulses every cycle on whichever path a test asks for
  always @(posedge mclk)
  begin
    osc_pulse <= run_osc;
    pll_pulse <= run_pll;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic tick_of(input int idx);
    case (idx)
      0:       tick_of = first_system_clock;
      1:       tick_of = second_system_clock;
      default: tick_of = third_system_clock;
    endcase
  endfunction : tick_of

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input string what);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp, what);
    @(posedge mclk);
    #1 check(reg_rdata, 16'h0000, "read data past its cycle");
  endtask : rd

  // spacing between the second and third tick; the first may be short after a ratio change
  task automatic gap(input int idx, input int n);
    int ticks;
    int cnt;
    int last;
    int t;
    ticks = 0;
    cnt = 0;
    last = 0;
    t = 0;
    while (ticks < 3 && t < 40)
    begin
      @(posedge mclk);
      #1 t++;
      cnt++;
      if (tick_of(idx) === 1'b1)
      begin
        ticks++;
        if (ticks == 3) last = cnt;
        cnt = 0;
      end
    end
    check(last[15:0], n[15:0], "tick spacing");
  endtask : gap

  task automatic quiet(input int cycles, input string what);
    int seen;
    seen = 0;
    repeat (2) @(posedge mclk);
    repeat (cycles)
    begin
      @(posedge mclk);
      #1 if ({first_system_clock, second_system_clock, third_system_clock} !== 3'h0) seen++;
    end
    check(seen[15:0], 16'h0000, what);
  endtask : quiet

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge mclk);
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    print_verdict;
  end

  initial
  begin
    errors = 0;
    n_compared = 0;
    rst = 1'b1;
    {bypass_mode, reg_wr, reg_rd, run_osc, run_pll} = 5'h00;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    #1 check({13'h0000, first_divider_on, second_divider_on, third_divider_on}, 16'h0007,
          "enables after reset");
    for (int i = 0; i < 3; i++) rd(ofs[i], 16'h8003, "reset value");
    $display("test reset done");
    foreach (rows[r])
    begin
      @(posedge mclk);
      bypass_mode <= rows[r].byp;
      run_osc     <= rows[r].byp;
      run_pll     <= !rows[r].byp;
      for (int i = 0; i < 3; i++) wr(ofs[i], 16'hFFE0 | {11'h000, rows[r].code});
      for (int i = 0; i < 3; i++) rd(ofs[i], {11'h400, rows[r].code}, "readback");
      for (int i = 0; i < 3; i++) gap(i, rows[r].n);
      $display("test row %0d done", r);
    end
    // pulses only on the path that is not selected must not reach any divider
    @(posedge mclk);
    run_osc <= 1'b0;
    run_pll <= 1'b1;
    quiet(12, "ticks from unselected path");
    @(posedge mclk);
    bypass_mode <= 1'b0;
    gap(0, 4);
    $display("test path select done");
    for (int i = 0; i < 3; i++) wr(ofs[i], 16'h7FE3);
    #1 check({13'h0000, first_divider_on, second_divider_on, third_divider_on}, 16'h0000,
          "enables after clear");
    quiet(12, "ticks while disabled");
    for (int i = 0; i < 3; i++) rd(ofs[i], 16'h0003, "disabled readback");
    wr(ofs[1], 16'h8001);
    gap(1, 2);
    $display("test enable done");
    wr(16'h1C92, 16'hFFFF);
    rd(16'h1C92, 16'h0000, "unmapped read");
    rd(ofs[0], 16'h0003, "after unmapped write");
    // write then read with no gap between the strobes
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= ofs[2];
    reg_wdata <= 16'hFFE1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, 16'h8001, "back to back readback");
    check({15'h0000, third_divider_on}, 16'h0001, "third enable");
    $display("test back to back done");
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
